/* File: phy_mgmt_pkg.sv */
// holds offsets, field positions, reset values and constants of the phy management registers
// assumes an apb slave with 32-bit data; each 16-bit register sits in the low half of a word
package phy_mgmt_pkg;
	// register indices (word offsets); byte address is four times the index
	localparam logic [2:0]  IDX_BASIC_CONTROL   = 3'h0;
	localparam logic [2:0]  IDX_BASIC_CONDITION = 3'h1;
	localparam logic [2:0]  IDX_IDENT_HIGH      = 3'h2;
	localparam logic [2:0]  IDX_IDENT_LOW       = 3'h3;
	localparam logic [2:0]  IDX_NEG_ADVERT      = 3'h4;
	localparam logic [2:0]  IDX_PARTNER         = 3'h5;
	localparam logic [2:0]  IDX_NEG_EXPANSION   = 3'h6;
	localparam int          IDX_LAST            = 6;
	localparam int          ADDR_LSB            = 2;
	localparam int          ADDR_W              = 5;
	// control field positions
	localparam int          CTL_SOFT_RESET      = 15;
	localparam int          CTL_WIRE_LOOPBACK   = 14;
	localparam int          CTL_SPEED_FAST      = 13;
	localparam int          CTL_NEG_ENABLE      = 12;
	localparam int          CTL_POWER_DOWN_REQ  = 11;
	localparam int          CTL_ISOLATE         = 10;
	localparam int          CTL_RENEGOTIATE     = 9;
	localparam int          CTL_DUPLEX_FORCE    = 8;
	localparam int          CTL_COLL_CHECK      = 7;
	// condition field positions
	localparam int          STA_NO_PREAMBLE_OK  = 6;
	localparam int          STA_NEG_DONE        = 5;
	localparam int          STA_FAR_END_FAULT   = 4;
	localparam int          STA_NEG_ABLE        = 3;
	localparam int          STA_LINK_UP_FLAG    = 2;
	localparam int          STA_JABBER_SEEN     = 1;
	// reset values and constant capability bits
	localparam logic [15:0] CONTROL_RESET       = 16'h1000;
	localparam logic [15:0] CONDITION_RESET     = 16'h7849;
	localparam logic [15:0] CAPABILITY_MASK     = 16'hfe09;
	localparam logic [15:0] ADVERT_RESET        = 16'h0001;
	localparam logic [15:0] ADVERT_WRITE_MASK   = 16'ha5e0;
	localparam logic [15:0] EXPANSION_BASE      = 16'h0004;
	// identifier: arbitrary neutral values
	localparam logic [21:0] OUI_BITS            = 22'h2a5a5a;
	localparam logic [5:0]  MODEL_NUMBER        = 6'h01;
	localparam logic [3:0]  REVISION_NUMBER     = 4'h0;
	localparam logic        PREAMBLE_SUPPRESS_OK = 1'b1;
endpackage : phy_mgmt_pkg

/* File: sticky_status_bit.sv */
// holds one latching status bit with clear-on-read
// assumes the read strobe is a one-cycle pulse of the register read
`timescale 1ns/1ps
module sticky_status_bit
	import phy_mgmt_pkg::*;
#(
	parameter logic LATCH_LEVEL = 1'b1
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic live_in,
	input  wire logic read_strobe,
	input  wire logic soft_clear,
	output logic      held_out
);
	logic latched_reg;

	// latch the event level; an event in the read cycle keeps the bit latched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_reg <= 1'b0;
		end else if (live_in == LATCH_LEVEL) begin
			latched_reg <= 1'b1;
		end else if (read_strobe || soft_clear) begin
			latched_reg <= 1'b0;
		end
	end

	// shows the latched level, or the live level once cleared by a read
	assign held_out = latched_reg ? LATCH_LEVEL : live_in;
endmodule : sticky_status_bit

/* File: phy_basic_mgmt_registers.sv */
// holds the basic management register set of a 10/100 phy behind an apb slave
// assumes pin inputs are synchronous to pclk and straps are stable at reset release
// Functional notes
// - seven 16-bit word registers at word offsets zero to six; no byte access.
// - soft reset bit restores defaults, restarts negotiation, then clears itself.
// - loopback bit loops transmit to receive and stops line transmission.
// - speed bit forces 100 or 10 when negotiation off; default from strap.
// - negotiation enable defaults from strap; clearing forces; re-setting restarts.
// - power down bit is stored but does nothing.
// - isolate bit floats rmii receive outputs and ignores transmit inputs.
// - restart bit restarts negotiation only while enabled; clears itself.
// - duplex bit forces full or half while negotiation is disabled.
// - collision test bit always reads zero.
// - capability flags read-only; t4 and t2 unsupported, 100/10 full/half supported.
// - preamble suppression flag reads one: such frames are accepted.
// - negotiation done bit reads one when complete, zero otherwise.
// - far end fault latches high until the register is read.
// - negotiation ability bit reads one.
// - link flag latches low so that a loss is held until read.
// - jabber latches high at 10 mbit/s and reads zero at 100 mbit/s.
// - extended register set present bit reads one.
// - latching bits hold their event until read, then follow live condition.
// - self-clearing bits give a one-cycle strobe, two cycles for restart written together with soft reset, and clear afterwards.
// - read-only 32-bit identifier of oui, model and revision.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module phy_basic_mgmt_registers
	import phy_mgmt_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        strap_neg_enable,
	input  wire logic        strap_speed_fast,
	input  wire logic        link_live,
	input  wire logic        far_end_fault_live,
	input  wire logic        jabber_live,
	input  wire logic        neg_done_in,
	input  wire logic        page_received_live,
	input  wire logic        parallel_fault_live,
	input  wire logic        partner_neg_able,
	input  wire logic        partner_next_page,
	input  wire logic [15:0] partner_word,
	input  wire logic        mac_tx_en,
	input  wire logic [1:0]  mac_txd,
	input  wire logic        line_rx_dv,
	input  wire logic [1:0]  line_rxd,
	output logic             line_tx_en,
	output logic [1:0]       line_txd,
	output logic             mac_crs_dv,
	output logic [1:0]       mac_rxd,
	output logic             mac_rx_oe_n,
	output logic             port_reset_strobe,
	output logic             neg_restart_strobe,
	output logic             speed_fast,
	output logic             duplex_full,
	output logic             neg_enable,
	output logic             wire_loopback,
	output logic             power_down_req
);
	logic [15:0] control_reg;
	logic [15:0] advert_reg;
	logic [15:0] rd_word;
	logic        strap_pending_reg;
	logic        port_reset_reg;
	logic        restart_reg;
	logic        link_up_flag;
	logic        far_end_fault;
	logic        jabber_seen;
	logic        page_rx_flag;
	logic        parallel_fault;
	logic        rd_cond;
	logic        rd_exp;
	logic        wr_ctl;
	logic        wr_adv;
	logic        access_ok;
	logic        jabber_qual;
	logic [2:0]  idx;

	// word index decode: aligned words only, no byte lanes below a word
	function automatic logic addr_valid(input logic [31:0] a);
		return (a[1:0] == 2'b00) && (a[31:ADDR_W] == '0) &&
			(int'(a[ADDR_W-1:ADDR_LSB]) <= IDX_LAST);
	endfunction : addr_valid

	assign idx       = paddr[ADDR_W-1:ADDR_LSB];
	assign access_ok = psel && penable && addr_valid(paddr);
	assign wr_ctl    = access_ok && pwrite && (idx == IDX_BASIC_CONTROL) && (&pstrb[1:0]);
	assign wr_adv    = access_ok && pwrite && (idx == IDX_NEG_ADVERT) && (&pstrb[1:0]);
	assign rd_cond   = access_ok && !pwrite && (idx == IDX_BASIC_CONDITION);
	assign rd_exp    = access_ok && !pwrite && (idx == IDX_NEG_EXPANSION);

	// control register; soft reset restores defaults but keeps strap-loaded values pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= CONTROL_RESET;
		end else if (strap_pending_reg) begin
			control_reg[CTL_NEG_ENABLE] <= strap_neg_enable;
			control_reg[CTL_SPEED_FAST] <= strap_neg_enable ? 1'b1 : strap_speed_fast;
		end else if (port_reset_reg) begin
			control_reg <= CONTROL_RESET;
		end else if (wr_ctl) begin
			control_reg <= pwdata[15:0] & 16'h7f00;
		end else begin
			control_reg[CTL_RENEGOTIATE] <= 1'b0;
		end
	end

	// straps are caught on the first clock after release, and again after a soft reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_pending_reg <= 1'b1;
		end else begin
			strap_pending_reg <= port_reset_reg;
		end
	end

	// one-cycle strobes for soft reset and renegotiation, restart held two cycles when one write asks for both; soft reset bit never reads back one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_reset_reg <= 1'b0;
			restart_reg    <= 1'b0;
		end else begin
			port_reset_reg <= wr_ctl && pwdata[CTL_SOFT_RESET];
			restart_reg    <= port_reset_reg ||
				(wr_ctl && pwdata[CTL_NEG_ENABLE] &&
				(pwdata[CTL_RENEGOTIATE] || !control_reg[CTL_NEG_ENABLE]));
		end
	end

	// advertisement register: only writable fields change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			advert_reg <= ADVERT_RESET;
		end else if (port_reset_reg) begin
			advert_reg <= ADVERT_RESET;
		end else if (wr_adv) begin
			advert_reg <= (pwdata[15:0] & ADVERT_WRITE_MASK) |
				(ADVERT_RESET & ~ADVERT_WRITE_MASK);
		end
	end

	// latching status bits, cleared by a read of their register
	sticky_status_bit #(.LATCH_LEVEL(1'b0)) u_link (
		.pclk        (pclk),
		.presetn     (presetn),
		.live_in     (link_live),
		.read_strobe (rd_cond),
		.soft_clear  (port_reset_reg),
		.held_out    (link_up_flag)
	);
	sticky_status_bit #(.LATCH_LEVEL(1'b1)) u_fault (
		.pclk        (pclk),
		.presetn     (presetn),
		.live_in     (far_end_fault_live),
		.read_strobe (rd_cond),
		.soft_clear  (port_reset_reg),
		.held_out    (far_end_fault)
	);
	// jabber only counts at 10 mbit/s
	assign jabber_qual = jabber_live && !speed_fast;
	sticky_status_bit #(.LATCH_LEVEL(1'b1)) u_jabber (
		.pclk        (pclk),
		.presetn     (presetn),
		.live_in     (jabber_qual),
		.read_strobe (rd_cond),
		.soft_clear  (port_reset_reg),
		.held_out    (jabber_seen)
	);
	sticky_status_bit #(.LATCH_LEVEL(1'b1)) u_page (
		.pclk        (pclk),
		.presetn     (presetn),
		.live_in     (page_received_live),
		.read_strobe (rd_exp),
		.soft_clear  (port_reset_reg),
		.held_out    (page_rx_flag)
	);
	sticky_status_bit #(.LATCH_LEVEL(1'b1)) u_pdf (
		.pclk        (pclk),
		.presetn     (presetn),
		.live_in     (parallel_fault_live),
		.read_strobe (rd_exp),
		.soft_clear  (port_reset_reg),
		.held_out    (parallel_fault)
	);

	// read multiplexer; reserved and unimplemented bits read zero
	always_comb begin
		rd_word = 16'h0000;
		case (idx)
			IDX_BASIC_CONTROL:   rd_word = control_reg & 16'h7f00;
			IDX_BASIC_CONDITION: begin
				rd_word = CONDITION_RESET & CAPABILITY_MASK;
				rd_word[STA_NO_PREAMBLE_OK] = PREAMBLE_SUPPRESS_OK;
				rd_word[STA_NEG_DONE]       = neg_done_in && neg_enable;
				rd_word[STA_FAR_END_FAULT]  = far_end_fault;
				rd_word[STA_LINK_UP_FLAG]   = link_up_flag;
				rd_word[STA_JABBER_SEEN]    = jabber_seen && !speed_fast;
			end
			IDX_IDENT_HIGH:      rd_word = OUI_BITS[21:6];
			IDX_IDENT_LOW:       rd_word = {OUI_BITS[5:0], MODEL_NUMBER, REVISION_NUMBER};
			IDX_NEG_ADVERT:      rd_word = advert_reg;
			IDX_PARTNER:         rd_word = partner_word; // valid only while done reads one
			IDX_NEG_EXPANSION:   rd_word = {11'h000, parallel_fault, partner_next_page,
				EXPANSION_BASE[2], page_rx_flag, partner_neg_able};
			default:             rd_word = 16'h0000;
		endcase
	end

	// apb answer: zero wait states, read data registered during the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_valid(paddr); // unmapped gives slverr
			prdata  <= (psel && !penable && !pwrite && addr_valid(paddr)) ?
				{16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	// control outputs; forced values apply only when negotiation is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_fast         <= 1'b1;
			duplex_full        <= 1'b0;
			neg_enable         <= 1'b1;
			wire_loopback      <= 1'b0;
			power_down_req     <= 1'b0;
			port_reset_strobe  <= 1'b0;
			neg_restart_strobe <= 1'b0;
		end else begin
			neg_enable         <= control_reg[CTL_NEG_ENABLE];
			speed_fast         <= control_reg[CTL_NEG_ENABLE] ? 1'b1 :
				control_reg[CTL_SPEED_FAST];
			duplex_full        <= control_reg[CTL_NEG_ENABLE] ? 1'b1 :
				control_reg[CTL_DUPLEX_FORCE];
			wire_loopback      <= control_reg[CTL_WIRE_LOOPBACK];
			power_down_req     <= control_reg[CTL_POWER_DOWN_REQ]; // stored, no effect
			port_reset_strobe  <= port_reset_reg;
			neg_restart_strobe <= restart_reg && control_reg[CTL_NEG_ENABLE];
		end
	end

	// data path: loopback mutes the line and returns transmit data; isolate floats receive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_tx_en  <= 1'b0;
			line_txd    <= 2'b00;
			mac_crs_dv  <= 1'b0;
			mac_rxd     <= 2'b00;
			mac_rx_oe_n <= 1'b1;
		end else begin
			line_tx_en  <= mac_tx_en && !control_reg[CTL_ISOLATE] &&
				!control_reg[CTL_WIRE_LOOPBACK];
			line_txd    <= (control_reg[CTL_ISOLATE] || control_reg[CTL_WIRE_LOOPBACK]) ?
				2'b00 : mac_txd;
			mac_crs_dv  <= control_reg[CTL_WIRE_LOOPBACK] ? mac_tx_en : line_rx_dv;
			mac_rxd     <= control_reg[CTL_WIRE_LOOPBACK] ? mac_txd : line_rxd;
			mac_rx_oe_n <= control_reg[CTL_ISOLATE]; // high floats the rmii receive pins
		end
	end
endmodule : phy_basic_mgmt_registers

/* File: phy_mgmt_chk.sv */
// holds concurrent checks on the apb side and control outputs of the phy register bank
// assumes one pclk domain and a zero-wait-state slave, bound onto the top module
`timescale 1ns/1ps
module phy_mgmt_chk
	import phy_mgmt_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        port_reset_strobe,
	input wire logic        neg_restart_strobe,
	input wire logic        neg_enable,
	input wire logic        speed_fast,
	input wire logic        duplex_full,
	input wire logic        mac_rx_oe_n,
	input wire logic        power_down_req,
	input wire logic        wire_loopback
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a write to the control register with both low byte lanes set, the bus path into the control outputs
	logic ctl_wr;
	assign ctl_wr = psel && penable && pwrite && paddr == 32'h0 && pstrb[1:0] == 2'h3;
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready stuck");
	property p_err; pslverr |-> pready && psel && penable; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access");
	property p_quiet; !pready |-> prdata == 32'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("prdata not idle");
	property p_rst_cause;
		$rose(port_reset_strobe) |-> $past(ctl_wr && pwdata[15], 2) || $past(ctl_wr && pwdata[15], 3);
	endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("port reset without write");
	property p_rst_pulse; port_reset_strobe |=> !port_reset_strobe; endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("port reset too long");
	property p_neg_pulse; neg_restart_strobe |=> !neg_restart_strobe; endproperty
	a_neg_pulse: assert property (p_neg_pulse) else $error("restart too long");
	property p_neg_en; neg_restart_strobe |-> ##[0:1] neg_enable; endproperty
	a_neg_en: assert property (p_neg_en) else $error("restart while disabled");
	// outputs follow the stored control word one edge after the access edge
	property p_iso; ctl_wr && !pwdata[15] |-> ##2 mac_rx_oe_n == $past(pwdata[10], 2); endproperty
	a_iso: assert property (p_iso) else $error("isolate mismatch");
	property p_pd; ctl_wr && !pwdata[15] |-> ##2 power_down_req == $past(pwdata[11], 2); endproperty
	a_pd: assert property (p_pd) else $error("power down mismatch");
	property p_loop; ctl_wr && !pwdata[15] |-> ##2 wire_loopback == $past(pwdata[14], 2); endproperty
	a_loop: assert property (p_loop) else $error("loopback mismatch");
	property p_speed;
		ctl_wr && !pwdata[15] |-> ##2 speed_fast == ($past(pwdata[12], 2) | $past(pwdata[13], 2));
	endproperty
	a_speed: assert property (p_speed) else $error("speed mismatch");
	property p_duplex;
		ctl_wr && !pwdata[15] |-> ##2 duplex_full == ($past(pwdata[12], 2) | $past(pwdata[8], 2));
	endproperty
	a_duplex: assert property (p_duplex) else $error("duplex mismatch");
	c_rst: cover property (port_reset_strobe);
	c_neg: cover property (neg_restart_strobe);
	c_err: cover property (pslverr);
endmodule : phy_mgmt_chk
bind phy_basic_mgmt_registers phy_mgmt_chk i_chk (.*);

/* File: line_side_model.sv */
// holds a stand-in for the rmii traffic on the mac and line sides of the phy
// assumes pclk paces the data; patterns change every cycle so stale values show
`timescale 1ns/1ps
module line_side_model (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      mac_tx_en,
	output logic [1:0] mac_txd,
	output logic      line_rx_dv,
	output logic [1:0] line_rxd
);
	logic [1:0] cnt_reg;
	// mac keeps transmitting so a suppressed line shows at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg    <= 2'h0;
			mac_tx_en  <= 1'b0;
			mac_txd    <= 2'h0;
			line_rx_dv <= 1'b0;
			line_rxd   <= 2'h0;
		end else begin
			cnt_reg    <= cnt_reg + 2'h1;
			mac_tx_en  <= 1'b1;
			mac_txd    <= cnt_reg;
			line_rx_dv <= cnt_reg[1];
			line_rxd   <= ~cnt_reg;
		end
	end
endmodule : line_side_model

/* File: tb_top.sv */
// holds the self-checking bench of the phy management register bank
// assumes the apb answer comes in the access cycle; waits are bounded anyway
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
	import phy_mgmt_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [31:0] paddr = 0, pwdata = 0, rv, prdata;
	logic [3:0] pstrb = 4'hf;
	logic strap_neg_enable = 1, strap_speed_fast = 1, link_live = 1, far_end_fault_live = 0;
	logic jabber_live = 0, neg_done_in = 1, page_received_live = 0, parallel_fault_live = 0;
	logic partner_neg_able = 1, partner_next_page = 0, mac_tx_en, line_rx_dv, line_tx_en;
	logic [15:0] partner_word = 16'h5a3c;
	logic [1:0] mac_txd, line_rxd, line_txd, mac_rxd;
	logic pready, pslverr, mac_crs_dv, mac_rx_oe_n, port_reset_strobe, neg_restart_strobe;
	logic speed_fast, duplex_full, neg_enable, wire_loopback, power_down_req;
	int fail_count = 0, comparisons = 0, negc = 0, rstc = 0, n0;
	always #2.5 pclk = ~pclk;
	phy_basic_mgmt_registers i_dut (.*);
	line_side_model i_line (.*);
	// strobes are counted at the edge, so a two-cycle strobe counts twice
	always @(posedge pclk) begin
		if (neg_restart_strobe === 1'b1) negc++;
		if (port_reset_strobe === 1'b1) rstc++;
	end
	task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d);
		int n = 0;
		// one idle edge first, so a release and the next setup never share a time step
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1;
		// pready, prdata and pslverr are taken at the rising edge that samples pready high
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		rv = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 50) fail_count++;
	endtask : apb
	task automatic rd(input logic [31:0] a, input logic [15:0] e, input logic [15:0] m, input string nm);
		apb(0, a, 16'h0);
		`CHK(nm, e, rv[15:0] & m)
		`CHK("upper half", 17'h0, {er, rv[31:16]})
	endtask : rd
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		apb(1, a, d);
		repeat (4) @(posedge pclk);
	endtask : wr
	task automatic t_status();
		rd(0, 16'h1000, 16'hdfff, "control reset");
		apb(0, 4, 16'h0);
		rd(4, 16'h786d, 16'hffff, "condition");
		far_end_fault_live <= 1; link_live <= 0; jabber_live <= 1;
		@(posedge pclk) far_end_fault_live <= 0;
		link_live <= 1; jabber_live <= 0;
		@(posedge pclk);
		rd(4, 16'h7879, 16'hffff, "latched");
		rd(4, 16'h786d, 16'hffff, "released");
	endtask : t_status
	task automatic t_forced();
		wr(0, 16'h0100);
		`CHK("speed", 1'b0, speed_fast)
		`CHK("duplex", 1'b1, duplex_full)
		`CHK("neg enable", 1'b0, neg_enable)
		jabber_live <= 1;
		@(posedge pclk) jabber_live <= 0;
		rd(4, 16'h0002, 16'h0022, "jabber at 10");
		n0 = negc;
		wr(0, 16'h0200);
		`CHK("no restart", n0, negc)
		wr(0, 16'h1000);
		`CHK("re-enable restart", n0 + 1, negc)
		wr(0, 16'h1200);
		`CHK("restart", n0 + 2, negc)
	endtask : t_forced
	task automatic t_modes();
		wr(0, 16'h5c80);
		rd(0, 16'h5c00, 16'hdfff, "control bits");
		`CHK("loop iso pd tx", 4'he, {wire_loopback, mac_rx_oe_n, power_down_req, line_tx_en})
		`CHK("loop crs rxd txd", {1'b1, mac_txd - 2'h1, 2'b00}, {mac_crs_dv, mac_rxd, line_txd})
		wr(0, 16'h1000);
		`CHK("plain iso pd tx", 4'h1, {wire_loopback, mac_rx_oe_n, power_down_req, line_tx_en})
	endtask : t_modes
	task automatic t_softreset();
		wr(0, 16'h1400);
		n0 = rstc;
		strap_speed_fast <= 0;
		wr(0, 16'h8000);
		`CHK("reset strobe", n0 + 1, rstc)
		`CHK("isolate cleared", 1'b0, mac_rx_oe_n)
		rd(0, 16'h1000, 16'hdfff, "control after reset");
		strap_speed_fast <= 1;
	endtask : t_softreset
	task automatic t_ident();
		rd(8, OUI_BITS[21:6], 16'hffff, "ident high");
		rd(12, {OUI_BITS[5:0], MODEL_NUMBER, REVISION_NUMBER}, 16'hffff, "ident low");
		wr(8, 16'hffff);
		rd(8, OUI_BITS[21:6], 16'hffff, "ident kept");
		rd(20, partner_word, 16'hffff, "partner");
		apb(0, 32'h1c, 16'h0);
		`CHK("unmapped", 33'h100000000, {er, rv})
		apb(0, 32'h2, 16'h0);
		`CHK("unaligned", 1'b1, er)
	endtask : t_ident
	task automatic end_of_test();
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		t_status();
		t_forced();
		t_modes();
		t_softreset();
		t_ident();
		end_of_test();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end
endmodule : tb_top
